// [sps_pkg.sv]
// Constants shared by the SPI clock-stop serial port block
package sps_pkg;
	localparam int          DIV_W         = 8;
	localparam int          WORD_W        = 8;
	localparam int          CNT_W         = 5;
	localparam logic [1:0]  STOP_MODE_A   = 2'h2;
	localparam logic [1:0]  STOP_MODE_B   = 2'h3;
	localparam logic        SRC_CPU       = 1'h1;
	localparam logic        SYNC_POL_SPI  = 1'h1;
	localparam logic [7:0]  DIV_RESET     = 8'h01;
	localparam logic [4:0]  CNT_ZERO      = 5'h00;
	localparam logic [4:0]  CNT_ONE       = 5'h01;

	typedef enum logic [4:0] {
		SPS_IDLE  = 5'b00001,
		SPS_LEAD  = 5'b00010,
		SPS_SHIFT = 5'b00100,
		SPS_TAIL  = 5'b01000,
		SPS_DONE  = 5'b10000
	} sps_state_e;
endpackage : sps_pkg

// [sps_serial_port.sv]
// SPI clock-stop serial port: divider, master clock and enable, slave shifter
`timescale 1ns/1ps
// What this block does
// - Bit clock period equals divider input period times one plus divide ratio, or two periods when the ratio is zero.
// - High phase lasts ratio/2+1 periods if even, (ratio+1)/2 if odd, one period if zero.
// - Low phase lasts ratio/2 periods if even, (ratio+1)/2 if odd, one period if zero.
// - Divider input is CPU clock when source select is 1, else external clock.
// - Sync polarities are 1; master drives inverted frame sync as active-low enable.
// - Slave inverts active-low enables on both frame sync inputs internally.
// - Master drives transmit clock and sync; receive clock and sync are inputs.
// - Slave sets all four clock and sync directions as inputs.
// - Enable goes low before a rising edge; transfer starts on that rising edge.
// - Setting 10b launches data after rising edges, captures on falling edges.
// - Master 10b: enable one low phase before first rise, one period after last fall.
// - Setting 11b captures on rising, launches after falling; enable one period early.
// - Slave 10b drives first bit after enable falls, releases output after deassert.
module sps_serial_port
	import sps_pkg::*;
#(
	parameter int DIVW = DIV_W,
	parameter int WW   = WORD_W
) (
	input  wire logic            clk_sys,
	input  wire logic            rst,
	input  wire logic            masterMode,
	input  wire logic [1:0]      clock_stop_setting,
	input  wire logic            divider_source_select,
	input  wire logic [DIVW-1:0] clock_divide_ratio,
	input  wire logic            tx_sync_polarity,
	input  wire logic            rx_sync_polarity,
	input  wire logic            external_source_clock,
	input  wire logic            startXfer,
	input  wire logic [WW-1:0]   txWord,
	output logic [WW-1:0]        rxWord_ff,
	output logic                 rxValid_ff,
	output logic                 busy_ff,
	input  wire logic            transmit_bit_clock_in,
	output logic                 transmit_bit_clock_ff,
	output logic                 transmit_bit_clock_oe_ff,
	input  wire logic            transmit_frame_sync_n_in,
	output logic                 transmit_frame_sync_n_ff,
	output logic                 transmit_frame_sync_oe_ff,
	input  wire logic            receive_frame_sync_n_in,
	output logic                 tx_clock_direction_ff,
	output logic                 rx_clock_direction_ff,
	output logic                 tx_sync_direction_ff,
	output logic                 rx_sync_direction_ff,
	input  wire logic            serial_data_in,
	output logic                 serial_data_out_ff,
	output logic                 serial_data_out_oe_ff
);
	// ==========================================================
	// Input synchronisers
	logic [1:0] extClkSync, sclkSync, fsxSync, fsrSync, dinSync;
	always_ff @(posedge clk_sys) begin
		extClkSync <= {extClkSync[0], external_source_clock};
		sclkSync   <= {sclkSync[0], transmit_bit_clock_in};
		fsxSync    <= {fsxSync[0], transmit_frame_sync_n_in};
		fsrSync    <= {fsrSync[0], receive_frame_sync_n_in};
		dinSync    <= {dinSync[0], serial_data_in};
	end

	// ==========================================================
	// Sample-rate divider input tick
	logic extClkPrev_ff;
	logic srcTick;
	always_ff @(posedge clk_sys) begin
		if (rst) extClkPrev_ff <= 1'b0;
		else     extClkPrev_ff <= extClkSync[1];
	end
	// External source counts on its rising edge only
	assign srcTick = (divider_source_select == SRC_CPU) ? 1'b1 : (extClkSync[1] & ~extClkPrev_ff);

	// Phase lengths; odd or zero ratio gives equal halves
	logic [DIVW:0] hiLen, loLen;
	always_comb begin
		if (clock_divide_ratio[0] == 1'b0 && clock_divide_ratio != '0) begin
			hiLen = {1'b0, clock_divide_ratio >> 1} + 1'b1;
			loLen = {1'b0, clock_divide_ratio >> 1};
		end else begin
			hiLen = (DIVW+1)'(({1'b0, clock_divide_ratio} + 1'b1) >> 1);
			loLen = hiLen;
		end
	end

	// ==========================================================
	// Slave clock edges
	logic sclkPrev_ff, sclkEdge, sclkFall;
	always_ff @(posedge clk_sys) begin
		if (rst) sclkPrev_ff <= 1'b0;
		else     sclkPrev_ff <= sclkSync[1];
	end
	assign sclkEdge = sclkPrev_ff ^ sclkSync[1];
	assign sclkFall = sclkPrev_ff & ~sclkSync[1];

	// ==========================================================
	// Master sequencer
	sps_state_e state_ff;
	logic [DIVW:0]  phaseCnt_ff;
	logic [CNT_W-1:0] bitCnt_ff;
	logic [WW-1:0]  txSh_ff, rxSh_ff;
	logic           phaseEnd;
	logic           modeB;
	logic           slvSeenCap_ff;
	assign modeB    = (clock_stop_setting == STOP_MODE_B);
	assign phaseEnd = srcTick && (phaseCnt_ff <= (DIVW+1)'(CNT_ONE));

	// Enable lead: one low phase for 10b, one full period for 11b
	logic [DIVW:0] leadLen;
	assign leadLen = modeB ? (hiLen + loLen) : loLen;

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			state_ff                 <= SPS_IDLE;
			phaseCnt_ff              <= '0;
			bitCnt_ff                <= CNT_ZERO;
			transmit_bit_clock_ff    <= 1'b0;
			transmit_frame_sync_n_ff <= 1'b1;
			txSh_ff                  <= '0;
			rxSh_ff                  <= '0;
			busy_ff                  <= 1'b0;
			slvSeenCap_ff            <= 1'b0;
		end else if (masterMode) begin
			case (state_ff)
				SPS_IDLE: begin
					transmit_bit_clock_ff <= 1'b0;
					if (startXfer) begin
						transmit_frame_sync_n_ff <= ~SYNC_POL_SPI;
						txSh_ff     <= txWord;
						phaseCnt_ff <= leadLen;
						bitCnt_ff   <= CNT_W'(WW);
						busy_ff     <= 1'b1;
						state_ff    <= SPS_LEAD;
					end
				end
				SPS_LEAD: begin
					if (srcTick) phaseCnt_ff <= phaseCnt_ff - 1'b1;
					if (phaseEnd) begin
						transmit_bit_clock_ff <= 1'b1;
						phaseCnt_ff <= hiLen;
						state_ff    <= SPS_SHIFT;
						// First rise of 11b is already a capture edge
						if (modeB) rxSh_ff <= {rxSh_ff[WW-2:0], dinSync[1]};
					end
				end
				SPS_SHIFT: begin
					if (srcTick) phaseCnt_ff <= phaseCnt_ff - 1'b1;
					if (phaseEnd) begin
						transmit_bit_clock_ff <= ~transmit_bit_clock_ff;
						phaseCnt_ff <= transmit_bit_clock_ff ? loLen : hiLen;
						if (transmit_bit_clock_ff != modeB) begin
							// Capture edge: falling for 10b, rising for 11b
							rxSh_ff <= {rxSh_ff[WW-2:0], dinSync[1]};
						end else begin
							txSh_ff <= {txSh_ff[WW-2:0], 1'b0};
						end
						if (transmit_bit_clock_ff && bitCnt_ff == CNT_ONE) begin
							transmit_bit_clock_ff <= 1'b0;
							phaseCnt_ff <= hiLen + loLen;
							state_ff    <= SPS_TAIL;
						end else if (transmit_bit_clock_ff) begin
							bitCnt_ff <= bitCnt_ff - 1'b1;
						end
					end
				end
				SPS_TAIL: begin
					if (srcTick) phaseCnt_ff <= phaseCnt_ff - 1'b1;
					if (phaseEnd) begin
						transmit_frame_sync_n_ff <= SYNC_POL_SPI;
						state_ff <= SPS_DONE;
					end
				end
				SPS_DONE: begin
					busy_ff  <= 1'b0;
					state_ff <= SPS_IDLE;
				end
				default: state_ff <= SPS_IDLE;
			endcase
		end else begin
			// Slave: frame comes from both inverted sync inputs
			transmit_bit_clock_ff    <= 1'b0;
			transmit_frame_sync_n_ff <= 1'b1;
			state_ff                 <= SPS_IDLE;
			busy_ff                  <= ~fsxSync[1] & ~fsrSync[1];
			if (!busy_ff) begin
				txSh_ff       <= txWord;
				slvSeenCap_ff <= 1'b0;
			end else if (sclkEdge && sclkFall != modeB) begin
				rxSh_ff       <= {rxSh_ff[WW-2:0], dinSync[1]};
				slvSeenCap_ff <= 1'b1;
			end else if (sclkEdge && slvSeenCap_ff) begin
				// Launch edge; the first bit already stands from the enable edge
				txSh_ff <= {txSh_ff[WW-2:0], 1'b0};
			end
		end
	end

	// ==========================================================
	// Pin directions, data output, received word
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			tx_clock_direction_ff     <= 1'b0;
			tx_sync_direction_ff      <= 1'b0;
			rx_clock_direction_ff     <= 1'b0;
			rx_sync_direction_ff      <= 1'b0;
			transmit_bit_clock_oe_ff  <= 1'b0;
			transmit_frame_sync_oe_ff <= 1'b0;
		end else begin
			tx_clock_direction_ff     <= masterMode;
			tx_sync_direction_ff      <= masterMode;
			rx_clock_direction_ff     <= 1'b0;
			rx_sync_direction_ff      <= 1'b0;
			transmit_bit_clock_oe_ff  <= masterMode;
			transmit_frame_sync_oe_ff <= masterMode;
		end
	end

	logic inFrame;
	assign inFrame = masterMode ? (state_ff != SPS_IDLE && state_ff != SPS_DONE) : busy_ff;
	// Output held high-impedance outside a frame so several slaves can share the line
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			serial_data_out_ff    <= 1'b0;
			serial_data_out_oe_ff <= 1'b0;
		end else begin
			serial_data_out_ff    <= txSh_ff[WW-1];
			serial_data_out_oe_ff <= inFrame;
		end
	end

	logic frameWasOn_ff;
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			frameWasOn_ff <= 1'b0;
			rxValid_ff    <= 1'b0;
			rxWord_ff     <= '0;
		end else begin
			frameWasOn_ff <= inFrame;
			rxValid_ff    <= frameWasOn_ff & ~inFrame;
			if (frameWasOn_ff & ~inFrame) rxWord_ff <= rxSh_ff;
		end
	end

	// ==========================================================
	// Checks
	idle_clock_low_a: assert property (@(posedge clk_sys) disable iff (rst)
		(masterMode && state_ff == SPS_IDLE) |=> !transmit_bit_clock_ff)
		else $error("bit clock not idle");
	enable_before_clock_a: assert property (@(posedge clk_sys) disable iff (rst)
		$rose(transmit_bit_clock_ff) && masterMode |-> !transmit_frame_sync_n_ff)
		else $error("clock rose with enable high");
	master_drives_pins_a: assert property (@(posedge clk_sys) disable iff (rst)
		masterMode ##1 masterMode |-> tx_clock_direction_ff && tx_sync_direction_ff && !rx_clock_direction_ff)
		else $error("master direction wrong");
	slave_all_inputs_a: assert property (@(posedge clk_sys) disable iff (rst)
		!masterMode ##1 !masterMode |-> !tx_clock_direction_ff && !tx_sync_direction_ff)
		else $error("slave direction wrong");
	slave_frame_inv_a: assert property (@(posedge clk_sys) disable iff (rst)
		!masterMode ##1 !masterMode |-> busy_ff == ($past(~fsxSync[1]) & $past(~fsrSync[1])))
		else $error("slave frame not inverted");
	cpu_source_tick_a: assert property (@(posedge clk_sys) disable iff (rst)
		divider_source_select && masterMode && state_ff == SPS_SHIFT && !phaseEnd
		|=> phaseCnt_ff == $past(phaseCnt_ff) - 1'b1)
		else $error("cpu source not counting every cycle");
	high_phase_len_a: assert property (@(posedge clk_sys) disable iff (rst)
		divider_source_select && masterMode && state_ff == SPS_SHIFT && clock_divide_ratio == 8'h04
		&& $rose(transmit_bit_clock_ff) |-> transmit_bit_clock_ff [*3])
		else $error("high phase too short");
	out_released_a: assert property (@(posedge clk_sys) disable iff (rst)
		!masterMode && !busy_ff |=> !serial_data_out_oe_ff)
		else $error("data not released");
endmodule : sps_serial_port

// [sps_spi_partner.sv]
// Far-side SPI peripheral model: slave to a master port, master to a slave port
`timescale 1ns/1ps
module sps_spi_partner (
	input  wire logic       stopB,
	input  wire logic       clkSeen,
	input  wire logic       enSeen_n,
	input  wire logic       dataSeen,
	input  wire logic [7:0] reply,
	output logic            dataOut,
	output logic            clkOut,
	output logic            enOut_n,
	output logic [7:0]      capWord
);
	int   capCnt   = 0;
	logic asMaster = 1'h0;
	initial begin
		dataOut = 1'h0;
		clkOut  = 1'h0;
		enOut_n = 1'h1;
	end
	// ==========
	// Slave role
	always @(negedge enSeen_n) if (!asMaster) begin
		capCnt  = 0;
		dataOut = reply[7];
	end
	// No pull on the line, so a released line shows the inverse of its last bit
	always @(posedge enSeen_n) if (!asMaster) dataOut = ~dataOut;
	always @(clkSeen) if (!asMaster && !enSeen_n) begin
		if (clkSeen ^ stopB) begin
			if (capCnt < 8) dataOut = reply[7 - capCnt];
		end else begin
			capWord = {capWord[6:0], dataSeen};
			capCnt++;
		end
	end
	// ==========
	// Master role, clock stands low outside the frame
	task automatic runFrame(input logic [7:0] w, input int hp);
		asMaster = 1'h1;
		enOut_n  = 1'h0;
		dataOut  = w[7];
		#hp;
		for (int i = 0; i < 8; i++) begin
			clkOut = 1'h1;
			if (stopB) capWord = {capWord[6:0], dataSeen};
			else dataOut = w[7 - i];
			#hp;
			clkOut = 1'h0;
			if (!stopB) capWord = {capWord[6:0], dataSeen};
			else if (i < 7) dataOut = w[6 - i];
			#hp;
		end
		enOut_n = 1'h1;
		dataOut = ~dataOut;
		#hp;
		asMaster = 1'h0;
	endtask : runFrame
endmodule : sps_spi_partner

// [tb_top.sv]
// Self-checking bench for the SPI clock-stop serial port
`timescale 1ns/1ps
module tb_top;
	import sps_pkg::*;
	logic       clk_sys = 1'h0, rst = 1'h1, extClk = 1'h0, masterMode = 1'h1, startXfer = 1'h0, src = 1'h1;
	logic [1:0] stopSet = STOP_MODE_A;
	logic [7:0] ratio   = 8'h04, txWord = 8'h00, reply = 8'h00, rxWord, capWord, gotRx;
	logic       rxValid, busy, clkQ, clkOe, enQ, enOe, dTc, dRc, dTs, dRs, dQ, dOe, pData, pClk, pEn, lastD = 1'h0;
	wire        clkW = clkOe ? clkQ : pClk;
	wire        enW  = enOe ? enQ : pEn;
	wire        dW   = dOe ? dQ : ~lastD;
	real        tEnF, tEnR, tR1, tRise, tFall;
	int         rises = 0, highNs, lowNs, perNs, nValid = 0, mismatches = 0, numChecks = 0;
	always #2.5 clk_sys = ~clk_sys;
	always #6.5 extClk = ~extClk;
	sps_serial_port dut_u (.clk_sys(clk_sys), .rst(rst), .masterMode(masterMode), .clock_stop_setting(stopSet),
		.divider_source_select(src), .clock_divide_ratio(ratio), .tx_sync_polarity(SYNC_POL_SPI),
		.rx_sync_polarity(SYNC_POL_SPI), .external_source_clock(extClk), .startXfer(startXfer), .txWord(txWord),
		.rxWord_ff(rxWord), .rxValid_ff(rxValid), .busy_ff(busy), .transmit_bit_clock_in(clkW),
		.transmit_bit_clock_ff(clkQ), .transmit_bit_clock_oe_ff(clkOe), .transmit_frame_sync_n_in(enW),
		.transmit_frame_sync_n_ff(enQ), .transmit_frame_sync_oe_ff(enOe), .receive_frame_sync_n_in(enW),
		.tx_clock_direction_ff(dTc), .rx_clock_direction_ff(dRc), .tx_sync_direction_ff(dTs),
		.rx_sync_direction_ff(dRs), .serial_data_in(pData), .serial_data_out_ff(dQ), .serial_data_out_oe_ff(dOe));
	sps_spi_partner peer_u (.stopB(stopSet[0]), .clkSeen(clkW), .enSeen_n(enW), .dataSeen(dW), .reply(reply),
		.dataOut(pData), .clkOut(pClk), .enOut_n(pEn), .capWord(capWord));
	// ==========
	// Monitors
	always @(posedge clk_sys) if (dOe) lastD <= dQ;
	always @(posedge clk_sys) if (rxValid === 1'h1) begin
		gotRx  <= rxWord;
		nValid <= nValid + 1;
	end
	always @(posedge clkW) begin
		if (rises == 0) tR1 = $realtime;
		else begin
			perNs = int'($realtime - tRise);
			lowNs = int'($realtime - tFall);
		end
		tRise = $realtime;
		rises++;
	end
	always @(negedge clkW) begin
		highNs = int'($realtime - tRise);
		tFall  = $realtime;
	end
	always @(negedge enW) tEnF = $realtime;
	always @(posedge enW) tEnR = $realtime;
	// ==========
	// Compares and closing
	task automatic chk_num(input string n, input int e, input int g, input int tol);
		numChecks++;
		if (g < e - tol || g > e + tol) begin
			mismatches++;
			$display("wrong value %s expected %0d seen %0d", n, e, g);
		end
	endtask : chk_num
	task automatic chk_val(input string n, input logic [7:0] e, input logic [7:0] g);
		numChecks++;
		if (g !== e) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask : chk_val
	task automatic complete_run;
		$display("checks %0d mismatches %0d", numChecks, mismatches);
		if (mismatches == 0 && numChecks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : complete_run
	// ==========
	// Scenarios
	task automatic master_case(input logic [1:0] m, input logic [7:0] r, input logic s, input logic [7:0] tx, rp);
		int rr, sn, t, h, l;
		rr = int'(r);
		sn = s ? 5 : 13;
		t  = (rr + 1) * sn;
		h  = (rr % 2 == 1 || rr == 0) ? (rr + 1) / 2 * sn : (rr / 2 + 1) * sn;
		l  = (rr % 2 == 1 || rr == 0) ? (rr + 1) / 2 * sn : rr / 2 * sn;
		@(negedge clk_sys);
		{masterMode, stopSet, src, ratio, txWord, reply, rises, nValid} = {1'h1, m, s, r, tx, rp, 64'h0};
		startXfer = 1'h1;
		// Held four cycles: the extra takes while busy must be refused
		repeat (4) @(negedge clk_sys);
		startXfer = 1'h0;
		for (int k = 0; k < 2000 && busy !== 1'h0; k++) @(negedge clk_sys);
		repeat (30) @(negedge clk_sys);
		chk_val("busy", 8'h00, {7'h0, busy});
		chk_num("rises", 8, rises, 0);
		chk_num("period", t, perNs, s ? 0 : 5);
		if (s) chk_num("high", h, highNs, 0);
		if (s) chk_num("low", l, lowNs, 0);
		chk_num("lead", m == STOP_MODE_A ? l : t, int'(tR1 - tEnF), s ? 5 : 13);
		if (m == STOP_MODE_A) chk_num("tail", t, int'(tEnR - tFall), s ? 5 : 13);
		chk_val("rx word", rp, gotRx);
		chk_val("tx word", tx, capWord);
		chk_num("valids", 1, nValid, 0);
		chk_val("dirs", 8'h3c, {2'h0, clkOe, enOe, dTc, dTs, dRc, dRs});
		$display("test master %h ratio %0d done", m, rr);
	endtask : master_case
	task automatic slave_case(input logic [1:0] m, input logic [7:0] tx, mw);
		@(negedge clk_sys);
		{masterMode, stopSet, src, ratio, txWord, nValid} = {1'h0, m, SRC_CPU, DIV_RESET, tx, 32'h0};
		repeat (4) @(negedge clk_sys);
		peer_u.runFrame(mw, 40);
		repeat (20) @(negedge clk_sys);
		chk_val("slave rx", mw, gotRx);
		chk_val("slave tx", tx, capWord);
		chk_val("slave dirs", 8'h00, {2'h0, enOe, clkOe, dTc, dTs, dRc, dRs});
		chk_val("released", 8'h00, {7'h0, dOe});
		chk_num("slave valids", 1, nValid, 0);
		$display("test slave %h done", m);
	endtask : slave_case
	initial begin
		repeat (6) @(posedge clk_sys);
		@(negedge clk_sys) rst = 1'h0;
		master_case(STOP_MODE_A, 8'h04, SRC_CPU, 8'ha5, 8'h3c);
		master_case(STOP_MODE_A, 8'h05, 1'h0, 8'h81, 8'h7e);
		master_case(STOP_MODE_B, 8'h06, SRC_CPU, 8'h5a, 8'hc3);
		master_case(STOP_MODE_B, 8'h07, SRC_CPU, 8'h0f, 8'he1);
		slave_case(STOP_MODE_A, 8'h96, 8'h69);
		slave_case(STOP_MODE_B, 8'h3c, 8'hd2);
		complete_run;
	end
	initial begin
		#200000;
		mismatches++;
		complete_run;
	end
endmodule : tb_top
